/* File: src/timing_watchdog.sv */
/*
 timing and watchdog module: tick prescaler, reloading period timer and an
 8-bit watchdog with count or key servicing and set-only register locks.
 assumes sys_clk_in is the slow clock, the bus master is on the same clock and
 a power-mode controller on the same clock drives pwr_mode_in.
*/
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module timing_watchdog (
   // clock and reset
   input  wire logic              sys_clk_in,
   input  wire logic              rst_in,
   // register port
   input  wire twm_pkg::bus_req_t bus_in,
   output logic [15:0]            rdata_out,
   // power mode
   input  wire twm_pkg::pwr_mode_t pwr_mode_in,
   // events
   output logic                   period_pulse_out,
   output logic                   timer_irq_line_out,
   output logic                   wd_reset_out
);
   logic [2:0]  presc_q;
   logic [4:0]  div_cnt_q;
   logic        tick;
   logic [15:0] preset_q;
   logic [15:0] tmr_q;
   logic        restart_q;
   logic        expired_q;
   logic        irq_en_q;
   logic        pulse_q;
   logic [5:0]  cfg_q;
   logic [7:0]  wd_count_q;
   logic [7:0]  wd_q;
   logic        wd_run_q;
   logic        svc_seen_q;
   logic        wd_err_q;
   logic        run;
   logic        active;
   logic        wr;
   logic        rd;
   logic        wd_clk;
   logic        svc;
   logic        bad_key;
   logic        wr_cfg;
   logic        wr_presc;
   logic        wr_preset;
   logic        wr_csr;
   logic        wr_watchdog_count;
   logic        wr_key;
   logic [4:0]  div_top;

   assign run    = (pwr_mode_in != twm_pkg::MODE_HALT);
   assign active = (pwr_mode_in == twm_pkg::MODE_ACTIVE);
   assign wr     = bus_in.wr && run;
   assign rd     = bus_in.rd && run;
   // locked registers drop writes; outside active mode only key writes pass, and none pass in halt
   assign wr_cfg    = wr && active && bus_in.addr == twm_pkg::OFF_CFG
                      && !cfg_q[twm_pkg::CFG_LOCK_CFG];
   assign wr_presc  = wr && active && bus_in.addr == twm_pkg::OFF_PRESC
                      && !cfg_q[twm_pkg::CFG_LOCK_PRESC];
   assign wr_preset = wr && active && bus_in.addr == twm_pkg::OFF_PRESET
                      && !cfg_q[twm_pkg::CFG_LOCK_TMR];
   assign wr_csr    = wr && active && bus_in.addr == twm_pkg::OFF_CSR
                      && !cfg_q[twm_pkg::CFG_LOCK_TMR];
   assign wr_watchdog_count  = wr && active && bus_in.addr == twm_pkg::OFF_WATCHDOG_COUNT
                      && !cfg_q[twm_pkg::CFG_LOCK_WD];
   assign wr_key    = wr && bus_in.addr == twm_pkg::OFF_KEY;

   // prescaler: divisor is 2^presc, reserved codes act as the largest divisor
   assign div_top = (presc_q > twm_pkg::PRESC_MAX) ?
                    5'h1f : 5'((6'h01 << presc_q) - 6'h01);
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         div_cnt_q <= 5'h00;
      end else if (run) begin
         div_cnt_q <= (div_cnt_q >= div_top) ? 5'h00 : div_cnt_q + 5'h01;
      end
   end
   assign tick = run && (div_cnt_q >= div_top);

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         presc_q <= 3'h0;
      end else if (wr_presc) begin
         presc_q <= bus_in.wdata[twm_pkg::PRESC_W-1:0];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         preset_q <= twm_pkg::PRESET_RST;
      end else if (wr_preset) begin
         preset_q <= bus_in.wdata;
      end
   end

   // period timer
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         tmr_q <= twm_pkg::PRESET_RST;
      end else if (tick) begin
         if (restart_q || tmr_q == 16'h0000) begin
            tmr_q <= preset_q;
         end else begin
            tmr_q <= tmr_q - 16'h0001;
         end
      end
   end

   // pulse lasts one tick period: set at zero tick, cleared at the next tick
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         pulse_q <= 1'b0;
      end else if (tick) begin
         pulse_q <= (tmr_q == 16'h0000) && !restart_q;
      end
   end
   assign period_pulse_out = pulse_q;

   // restart bit, hardware clear wins once the reload has happened
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         restart_q <= 1'b0;
      end else if (tick && restart_q) begin
         restart_q <= 1'b0;
      end else if (wr_csr && bus_in.wdata[twm_pkg::CSR_RESTART]) begin
         restart_q <= 1'b1;
      end
   end

   // expired flag: set beats a write-zero in the same cycle
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         expired_q <= 1'b0;
      end else if (tick && tmr_q == 16'h0000 && !restart_q) begin
         expired_q <= 1'b1;
      end else if (wr_csr) begin
         expired_q <= bus_in.wdata[twm_pkg::CSR_EXPIRED];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         irq_en_q <= 1'b0;
      end else if (wr_csr) begin
         irq_en_q <= bus_in.wdata[twm_pkg::CSR_IRQ_EN];
      end
   end
   assign timer_irq_line_out = pulse_q && irq_en_q;

   // config: lock bits only ever set; the rest follow writes
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cfg_q <= 6'h00;
      end else if (wr_cfg) begin
         cfg_q[3:0] <= cfg_q[3:0] | bus_in.wdata[3:0];
         cfg_q[twm_pkg::CFG_WD_CLKSEL] <= bus_in.wdata[twm_pkg::CFG_WD_CLKSEL];
         cfg_q[twm_pkg::CFG_KEY_EN]    <= bus_in.wdata[twm_pkg::CFG_KEY_EN];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         wd_count_q <= 8'h00;
      end else if (wr_watchdog_count) begin
         wd_count_q <= bus_in.wdata[7:0];
      end
   end

   // watchdog clock: each prescaler tick, or the zero-count tick that sets the period pulse
   assign wd_clk = cfg_q[twm_pkg::CFG_WD_CLKSEL] ? tick
                   : (tick && tmr_q == 16'h0000 && !restart_q);
   assign svc = (wr_watchdog_count && !cfg_q[twm_pkg::CFG_KEY_EN])
                || (wr_key && cfg_q[twm_pkg::CFG_KEY_EN]
                    && bus_in.wdata[7:0] == twm_pkg::SERVICE_KEY);
   assign bad_key = wr_key && cfg_q[twm_pkg::CFG_KEY_EN]
                    && bus_in.wdata[7:0] != twm_pkg::SERVICE_KEY;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         wd_run_q <= 1'b0;
      end else if (wr_watchdog_count || wr_key) begin
         wd_run_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         wd_q <= 8'h00;
      end else if (!wd_run_q && wr_watchdog_count) begin
         wd_q <= bus_in.wdata[7:0];
      end else if (!wd_run_q && wr_key) begin
         wd_q <= wd_count_q;
      end else if (svc) begin
         wd_q <= wr_watchdog_count ? bus_in.wdata[7:0] : wd_count_q;
      end else if (wd_run_q && wd_clk && wd_q != 8'h00) begin
         wd_q <= wd_q - 8'h01;
      end
   end

   // a second service before the next watchdog clock is too frequent
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         svc_seen_q <= 1'b0;
      end else if (svc && wd_run_q) begin
         svc_seen_q <= 1'b1;
      end else if (wd_clk) begin
         svc_seen_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         wd_err_q <= 1'b0;
      end else if (wd_run_q && ((wd_clk && wd_q == 8'h00 && !svc)
                                || (svc && svc_seen_q) || bad_key)) begin
         wd_err_q <= 1'b1;
      end
   end
   assign wd_reset_out = wd_err_q;

   // read data; locked registers read zero
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         rdata_out <= 16'h0000;
      end else if (rd && active) begin
         case (bus_in.addr)
            twm_pkg::OFF_CFG:    rdata_out <= cfg_q[twm_pkg::CFG_LOCK_CFG] ? 16'h0000
                                              : {10'h000, cfg_q};
            twm_pkg::OFF_PRESC:  rdata_out <= cfg_q[twm_pkg::CFG_LOCK_PRESC] ? 16'h0000
                                              : {13'h0000, presc_q};
            twm_pkg::OFF_PRESET: rdata_out <= cfg_q[twm_pkg::CFG_LOCK_TMR] ? 16'h0000
                                              : preset_q;
            twm_pkg::OFF_CSR:    rdata_out <= cfg_q[twm_pkg::CFG_LOCK_TMR] ? 16'h0000
                                              : {13'h0000, irq_en_q, expired_q, restart_q};
            twm_pkg::OFF_WATCHDOG_COUNT:  rdata_out <= cfg_q[twm_pkg::CFG_LOCK_WD] ? 16'h0000
                                              : {8'h00, wd_count_q};
            default:             rdata_out <= 16'h0000;
         endcase
      end else begin
         rdata_out <= 16'h0000;
      end
   end

   a_irq_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      timer_irq_line_out |-> (period_pulse_out && irq_en_q))
      else $error("timer irq without pulse and enable");
   a_pulse_sets_flag: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      $rose(period_pulse_out) |-> expired_q)
      else $error("pulse did not set expired flag");
   a_reload_preset: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (tick && tmr_q == 16'h0000) |=> (tmr_q == $past(preset_q)))
      else $error("timer did not reload from preset");
   a_timer_step: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (tick && tmr_q != 16'h0000 && !restart_q) |=> (tmr_q == $past(tmr_q) - 16'h0001))
      else $error("timer did not decrement");
   a_restart_clears: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (tick && restart_q) |=> (!restart_q && tmr_q == $past(preset_q)))
      else $error("restart not taken");
   a_wd_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      !wd_run_q |-> (wd_q == 8'h00 && !wd_reset_out))
      else $error("watchdog active before start");
   a_wd_sticky: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      wd_run_q |=> wd_run_q)
      else $error("watchdog stopped");
   a_lock_sticky: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      $past(cfg_q[0]) |-> cfg_q[0])
      else $error("config lock cleared");
   a_bad_key_err: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (bad_key && wd_run_q) |=> wd_reset_out)
      else $error("wrong key gave no error");
   a_halt_freeze: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (pwr_mode_in == twm_pkg::MODE_HALT) |=> (tmr_q == $past(tmr_q) && wd_q == $past(wd_q)))
      else $error("counters moved in halt");
   // count servicing takes the written value, not the stored one
   a_count_reload: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (wr_watchdog_count && !cfg_q[twm_pkg::CFG_KEY_EN]) |=> (wd_q == $past(bus_in.wdata[7:0])))
      else $error("count write did not reload watchdog");
   // with key servicing off a running watchdog must not notice key writes
   a_key_ignored: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (wr_key && !cfg_q[twm_pkg::CFG_KEY_EN] && wd_run_q && !wd_clk)
      |=> (wd_q == $past(wd_q) && !wd_reset_out))
      else $error("key write acted with key service off");
   a_key_reload: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (wr_key && svc) |=> (wd_q == $past(wd_count_q)))
      else $error("key service did not reload stored count");
   // a locked prescaler must hold its value against any write
   a_lock_drops: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (bus_in.wr && bus_in.addr == twm_pkg::OFF_PRESC && cfg_q[twm_pkg::CFG_LOCK_PRESC])
      |=> (presc_q == $past(presc_q)))
      else $error("locked prescaler changed");
   a_inactive_drops: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (bus_in.wr && !active && bus_in.addr == twm_pkg::OFF_PRESET)
      |=> (preset_q == $past(preset_q)))
      else $error("preset written outside active mode");
   // legal presets are at least one, so the pulse drops at the following tick
   a_pulse_one_tick: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (pulse_q && tick && preset_q != 16'h0000) |=> !pulse_q)
      else $error("period pulse longer than one tick");
   // the error must hold until reset so the device reset cannot be missed
   a_err_sticky: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      wd_reset_out |=> wd_reset_out)
      else $error("watchdog error dropped");
   a_cfg_reset: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      $past(rst_in) |-> (cfg_q == 6'h00))
      else $error("config not cleared by reset");
endmodule : timing_watchdog
`default_nettype wire

/* File: src/twm_pkg.sv */
/*
 timing and watchdog package: register offsets, field positions, reset values,
 mode encodings and the shared bus carrier.
 assumes byte-wide or word-wide registers reached on a plain strobe port.
*/
package twm_pkg;
   localparam int ADDR_W = 24;
   localparam logic [23:0] OFF_CFG    = 24'hffff20;
   localparam logic [23:0] OFF_PRESC  = 24'hffff22;
   localparam logic [23:0] OFF_PRESET = 24'hffff24;
   localparam logic [23:0] OFF_CSR    = 24'hffff26;
   localparam logic [23:0] OFF_WATCHDOG_COUNT  = 24'hffff28;
   localparam logic [23:0] OFF_KEY    = 24'hffff2a;
   // config fields
   localparam int CFG_LOCK_CFG   = 0;
   localparam int CFG_LOCK_PRESC = 1;
   localparam int CFG_LOCK_TMR   = 2;
   localparam int CFG_LOCK_WD    = 3;
   localparam int CFG_WD_CLKSEL  = 4;
   localparam int CFG_KEY_EN     = 5;
   localparam logic [7:0] CFG_MASK = 8'h3f;
   // control/status fields
   localparam int CSR_RESTART = 0;
   localparam int CSR_EXPIRED = 1;
   localparam int CSR_IRQ_EN  = 2;
   localparam int PRESC_W     = 3;
   localparam logic [2:0]  PRESC_MAX  = 3'h5;
   localparam logic [15:0] PRESET_RST = 16'hffff;
   localparam logic [7:0]  SERVICE_KEY = 8'h5c;
   typedef enum logic [1:0] {MODE_ACTIVE, MODE_SAVE, MODE_IDLE, MODE_HALT} pwr_mode_t;
   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;
endpackage : twm_pkg

/* File: sim/tb_top.sv */
/*
 bench for the timing and watchdog block: bus tasks and one task per scenario.
 assumes reads answer one cycle after the strobe; locked or inactive reads give 0.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic               sys_clk_in = 1'b0;
   logic               rst_in = 1'b1;
   twm_pkg::bus_req_t  bus = '0;
   twm_pkg::pwr_mode_t mode = twm_pkg::MODE_ACTIVE;
   logic [15:0]        rdata;
   logic [15:0]        d;
   logic               pulse;
   logic               irq;
   logic               wd_rst;
   logic               pulse_d = 1'b0;
   int                 cyc = 0;
   int                 n_mismatch = 0;
   int                 n_compared = 0;
   int                 t0;
   int                 t1;
   int                 t2;
   int                 n;

   timing_watchdog dut (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus), .rdata_out(rdata),
      .pwr_mode_in(mode), .period_pulse_out(pulse), .timer_irq_line_out(irq),
      .wd_reset_out(wd_rst));

   always #25 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      pulse_d <= pulse;
      cyc <= cyc + 1;
      // whole run is well under two thousand cycles
      if (cyc == 20000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic test_done();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [23:0] a, input logic [15:0] v);
      @(posedge sys_clk_in);
      bus.addr <= a;
      bus.wdata <= v;
      bus.wr <= 1'b1;
      @(posedge sys_clk_in);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [23:0] a);
      @(posedge sys_clk_in);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge sys_clk_in);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd

   task automatic idle(input int k);
      repeat (k) @(posedge sys_clk_in);
      #1;
   endtask : idle

   // stamps the cycle of the next rising edge of the period pulse
   task automatic rise(output int t);
      int k;
      k = 0;
      do begin
         @(posedge sys_clk_in);
         #1;
         k++;
      end while (!(pulse === 1'b1 && pulse_d === 1'b0) && k < 3000);
      t = cyc;
   endtask : rise

   task automatic wait_wd(output int k);
      k = 0;
      while (wd_rst !== 1'b1 && k < 40) begin
         @(posedge sys_clk_in);
         #1;
         k++;
      end
   endtask : wait_wd

   task automatic do_reset();
      @(posedge sys_clk_in);
      rst_in <= 1'b1;
      repeat (10) @(posedge sys_clk_in);
      rst_in <= 1'b0;
   endtask : do_reset

   task automatic t_reset_values();
      rd(twm_pkg::OFF_CFG);
      chk(d, 16'h0000);
      rd(twm_pkg::OFF_PRESET);
      chk(d, 16'hffff);
      rd(twm_pkg::OFF_CSR);
      chk(d, 16'h0000);
      rd(24'hffff2c);
      chk(d, 16'h0000);
   endtask : t_reset_values

   task automatic t_period();
      wr(twm_pkg::OFF_PRESET, 16'h0003);
      wr(twm_pkg::OFF_CSR, 16'h0001);
      rise(t0);
      rise(t1);
      chk(t1 - t0, 4);
      chk(irq, 1'b0);
      idle(1);
      chk(pulse, 1'b0);
      rd(twm_pkg::OFF_CSR);
      chk(d & 16'h0003, 16'h0002);
      wr(twm_pkg::OFF_CSR, 16'h0004);
      rise(t0);
      chk(irq, 1'b1);
   endtask : t_period

   task automatic t_preset_change();
      rise(t0);
      wr(twm_pkg::OFF_PRESET, 16'h0007);
      rise(t1);
      rise(t2);
      chk(t1 - t0, 4);
      chk(t2 - t1, 8);
      wr(twm_pkg::OFF_PRESET, 16'h0003);
   endtask : t_preset_change

   task automatic t_prescaler();
      for (int p = 0; p < 6; p++) begin
         wr(twm_pkg::OFF_PRESC, 16'(p));
         rise(t0);
         rise(t1);
         rise(t2);
         chk(t2 - t1, 4 << p);
         n = 0;
         while (pulse === 1'b1 && n < 100) begin
            @(posedge sys_clk_in);
            #1;
            n++;
         end
         chk(n, 1 << p);
      end
      wr(twm_pkg::OFF_PRESC, 16'h0000);
   endtask : t_prescaler

   task automatic t_power();
      // last restart and count service lie far more than five clocks back
      @(posedge sys_clk_in);
      mode <= twm_pkg::MODE_SAVE;
      wr(twm_pkg::OFF_PRESET, 16'h0007);
      rd(twm_pkg::OFF_PRESET);
      chk(d, 16'h0000);
      rise(t0);
      rise(t1);
      chk(t1 - t0, 4);
      @(posedge sys_clk_in);
      mode <= twm_pkg::MODE_ACTIVE;
      rd(twm_pkg::OFF_PRESET);
      chk(d, 16'h0003);
      rise(t0);
      @(posedge sys_clk_in);
      mode <= twm_pkg::MODE_HALT;
      n = 0;
      repeat (19) begin
         @(posedge sys_clk_in);
         #1;
         if (pulse !== pulse_d)
            n++;
      end
      chk(n, 0);
      @(posedge sys_clk_in);
      mode <= twm_pkg::MODE_ACTIVE;
      rise(t1);
      // twenty frozen edges stretch one four-cycle period
      chk(t1 - t0, 24);
   endtask : t_power

   task automatic t_lock();
      wr(twm_pkg::OFF_CFG, 16'h0002);
      wr(twm_pkg::OFF_CFG, 16'h0000);
      rd(twm_pkg::OFF_CFG);
      chk(d, 16'h0002);
      wr(twm_pkg::OFF_PRESC, 16'h0002);
      rd(twm_pkg::OFF_PRESC);
      chk(d, 16'h0000);
      rise(t0);
      rise(t1);
      rise(t2);
      chk(t2 - t1, 4);
   endtask : t_lock

   task automatic t_wd_late();
      chk(wd_rst, 1'b0);
      wr(twm_pkg::OFF_CFG, 16'h0010);
      wr(twm_pkg::OFF_WATCHDOG_COUNT, 16'h0003);
      wait_wd(n);
      chk(wd_rst, 1'b1);
      chk(n >= 4 && n <= 6, 1);
      do_reset();
      chk(wd_rst, 1'b0);
   endtask : t_wd_late

   task automatic t_wd_select();
      // period pulse clock at reset preset is far too slow to expire here
      wr(twm_pkg::OFF_WATCHDOG_COUNT, 16'h0001);
      idle(40);
      chk(wd_rst, 1'b0);
      do_reset();
   endtask : t_wd_select

   task automatic t_wd_count();
      wr(twm_pkg::OFF_CFG, 16'h0010);
      wr(twm_pkg::OFF_WATCHDOG_COUNT, 16'h0008);
      repeat (6) begin
         idle(4);
         wr(twm_pkg::OFF_WATCHDOG_COUNT, 16'h0008);
      end
      wr(twm_pkg::OFF_KEY, 16'h0000);
      idle(2);
      chk(wd_rst, 1'b0);
      do_reset();
   endtask : t_wd_count

   task automatic t_wd_key();
      wr(twm_pkg::OFF_CFG, 16'h0030);
      wr(twm_pkg::OFF_WATCHDOG_COUNT, 16'h0008);
      repeat (6) begin
         idle(4);
         wr(twm_pkg::OFF_KEY, 16'h005c);
      end
      chk(wd_rst, 1'b0);
      wr(twm_pkg::OFF_KEY, 16'h005d);
      wait_wd(n);
      chk(wd_rst, 1'b1);
      chk(n <= 3, 1);
      do_reset();
   endtask : t_wd_key

   task automatic t_wd_often();
      wr(twm_pkg::OFF_CFG, 16'h0020);
      wr(twm_pkg::OFF_WATCHDOG_COUNT, 16'h0008);
      wr(twm_pkg::OFF_KEY, 16'h005c);
      wr(twm_pkg::OFF_KEY, 16'h005c);
      wait_wd(n);
      chk(wd_rst, 1'b1);
   endtask : t_wd_often

   initial begin
      do_reset();
      t_reset_values();
      t_period();
      t_preset_change();
      t_prescaler();
      t_power();
      t_lock();
      t_wd_late();
      t_wd_select();
      t_wd_count();
      t_wd_key();
      t_wd_often();
      test_done();
   end
endmodule : tb_top
`default_nettype wire
